/* src/jtdr_map.vh */
// constants for the test data register block
`ifndef JTDR_MAP_VH
`define JTDR_MAP_VH
`define JTDR_IR_W 5
`define JTDR_IR_CAPTURE 5'h01
`define JTDR_OP_EXTEST 5'h00
`define JTDR_OP_SAMPLE 5'h01
`define JTDR_OP_CLAMP 5'h04
`define JTDR_OP_HIGHZ 5'h05
`define JTDR_OP_IDCODE 5'h06
`define JTDR_OP_BYPASS 5'h1F
`define JTDR_SIG_W 32
`define JTDR_SIG_VER_HI 31
`define JTDR_SIG_VER_LO 28
`define JTDR_SIG_FIXED_W 28
`define JTDR_BYP_CAPTURE 1'h0
`define JTDR_TAP_RESET 4'hF
`define JTDR_TAP_IDLE 4'hC
`define JTDR_TAP_SEL_DR 4'h7
`define JTDR_TAP_CAP_DR 4'h6
`define JTDR_TAP_SH_DR 4'h2
`define JTDR_TAP_EX1_DR 4'h1
`define JTDR_TAP_PA_DR 4'h3
`define JTDR_TAP_EX2_DR 4'h0
`define JTDR_TAP_UP_DR 4'h5
`define JTDR_TAP_SEL_IR 4'h4
`define JTDR_TAP_CAP_IR 4'hE
`define JTDR_TAP_SH_IR 4'hA
`define JTDR_TAP_EX1_IR 4'h9
`define JTDR_TAP_PA_IR 4'hB
`define JTDR_TAP_EX2_IR 4'h8
`define JTDR_TAP_UP_IR 4'hD
`endif

/* src/jtdr_sync.v */
// two-flop synchroniser with edge pulses for the test clock
`timescale 1ns/1ns
`default_nettype none
module jtdr_sync (
  input wire clk,
  input wire rst_b,
  input wire tck_pin,
  input wire tms_pin,
  input wire tdi_pin,
  input wire trst_b_pin,
  output reg tck_rise,
  output reg tck_fall,
  output reg tms_s,
  output reg tdi_s,
  output reg trst_b_s
);
  reg [3:0] meta_r;
  reg tck_s_r;
  reg tck_d_r;
  always @(posedge clk) begin
    if (!rst_b) begin
      meta_r <= 4'h0;
      tck_s_r <= 1'b0;
      tck_d_r <= 1'b0;
      tms_s <= 1'b1;
      tdi_s <= 1'b1;
      trst_b_s <= 1'b0;
      tck_rise <= 1'b0;
      tck_fall <= 1'b0;
    end else begin
      meta_r <= {trst_b_pin, tdi_pin, tms_pin, tck_pin};
      tck_s_r <= meta_r[0];
      tck_d_r <= tck_s_r;
      tms_s <= meta_r[1];
      tdi_s <= meta_r[2];
      trst_b_s <= meta_r[3];
      // edges are found after the second stage only; the first stage may be metastable
      tck_rise <= tck_s_r & ~tck_d_r;
      tck_fall <= ~tck_s_r & tck_d_r;
    end
  end
endmodule
`default_nettype wire

/* src/jtdr_cell_chain.v */
// boundary-scan chain: shift stage and update latch per cell
`timescale 1ns/1ns
`default_nettype none
module jtdr_cell_chain #(
  parameter N = 8
) (
  input wire clk,
  input wire rst_b,
  input wire capture_en,
  input wire shift_en,
  input wire update_en,
  input wire clr,
  input wire serial_in,
  input wire [N-1:0] capture_vals,
  output wire serial_out,
  output reg [N-1:0] update_vals
);
  reg [N-1:0] shift_r;
  // cell 0 is nearest the serial input, cell N-1 drives the output
  assign serial_out = shift_r[N-1];
  genvar g;
  generate
    for (g = 0; g < N; g = g + 1) begin : g_cell
      always @(posedge clk) begin
        if (!rst_b || clr) begin
          shift_r[g] <= 1'b0;
          update_vals[g] <= 1'b0;
        end else begin
          if (capture_en) begin
            shift_r[g] <= capture_vals[g];
          end else if (shift_en) begin
            shift_r[g] <= (g == 0) ? serial_in : shift_r[(g == 0) ? 0 : g - 1];
          end
          if (update_en) begin
            update_vals[g] <= shift_r[g];
          end
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

/* src/jtdr_top.v */
// test data registers, instruction register and pad muxing behind the test port
// Functional notes
// - one-bit skip register between serial pins
// - skip path delays data one test clock
// - skip register captures zero
// - skip register drives nothing else
// - fixed 32-bit signature, no user code
// - signature register selected under IDCODE
// - version top four bits, fixed code below
// - signature captured whole, no parallel output
// - cell chain selected only for sample/extest
// - clamp keeps update latches driving pins
// - system mode passes core to pads
// - extest drives pins from update latches
// - every cell has an update latch
// - extra cell enables data bus drivers
// - fixed chain order from serial input
// - serial output driven only in shift states
// - logic static when test clock stops
// - capture latches core and pad values
// - sample on rise, change output on fall
// - five-bit instruction, captures 00001
// - instruction codes decode as listed
`timescale 1ns/1ns
`default_nettype none
`include "jtdr_map.vh"
module jtdr_top #(
  parameter N_IN = 4,
  parameter N_OUT = 4,
  parameter N_DBUS = 4,
  parameter [3:0] SIG_VERSION = 4'h1,
  // arbitrary neutral code, no real maker or part
  parameter [27:0] SIG_FIXED = 28'h0000001
) (
  input wire clk,
  input wire rst_b,
  input wire tck,
  input wire tms,
  input wire tdi,
  input wire trst_b,
  output reg tdo,
  output reg tdo_oe,
  input wire [N_IN-1:0] pad_in,
  output wire [N_IN-1:0] core_in,
  input wire [N_OUT-1:0] core_out,
  output wire [N_OUT-1:0] pad_out,
  input wire [N_DBUS-1:0] core_dbus_out,
  input wire core_dbus_oe,
  input wire [N_DBUS-1:0] pad_dbus_in,
  output wire [N_DBUS-1:0] core_dbus_in,
  output wire [N_DBUS-1:0] pad_dbus_out,
  output wire pad_dbus_oe,
  output wire pads_highz,
  output wire [`JTDR_IR_W-1:0] active_instr
);
  localparam N = N_IN + N_OUT + 1 + 2 * N_DBUS;
  localparam [N-1:0] ZERO_N = {N{1'b0}};
  wire tck_rise;
  wire tck_fall;
  wire tms_s;
  wire tdi_s;
  wire trst_b_s;
  jtdr_sync u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .tck_pin(tck),
    .tms_pin(tms),
    .tdi_pin(tdi),
    .trst_b_pin(trst_b),
    .tck_rise(tck_rise),
    .tck_fall(tck_fall),
    .tms_s(tms_s),
    .tdi_s(tdi_s),
    .trst_b_s(trst_b_s)
  );

  function [3:0] tap_next;
    input [3:0] st;
    input m;
    begin
      case (st)
        `JTDR_TAP_RESET: tap_next = m ? `JTDR_TAP_RESET : `JTDR_TAP_IDLE;
        `JTDR_TAP_IDLE: tap_next = m ? `JTDR_TAP_SEL_DR : `JTDR_TAP_IDLE;
        `JTDR_TAP_SEL_DR: tap_next = m ? `JTDR_TAP_SEL_IR : `JTDR_TAP_CAP_DR;
        `JTDR_TAP_CAP_DR: tap_next = m ? `JTDR_TAP_EX1_DR : `JTDR_TAP_SH_DR;
        `JTDR_TAP_SH_DR: tap_next = m ? `JTDR_TAP_EX1_DR : `JTDR_TAP_SH_DR;
        `JTDR_TAP_EX1_DR: tap_next = m ? `JTDR_TAP_UP_DR : `JTDR_TAP_PA_DR;
        `JTDR_TAP_PA_DR: tap_next = m ? `JTDR_TAP_EX2_DR : `JTDR_TAP_PA_DR;
        `JTDR_TAP_EX2_DR: tap_next = m ? `JTDR_TAP_UP_DR : `JTDR_TAP_SH_DR;
        `JTDR_TAP_UP_DR: tap_next = m ? `JTDR_TAP_SEL_DR : `JTDR_TAP_IDLE;
        `JTDR_TAP_SEL_IR: tap_next = m ? `JTDR_TAP_RESET : `JTDR_TAP_CAP_IR;
        `JTDR_TAP_CAP_IR: tap_next = m ? `JTDR_TAP_EX1_IR : `JTDR_TAP_SH_IR;
        `JTDR_TAP_SH_IR: tap_next = m ? `JTDR_TAP_EX1_IR : `JTDR_TAP_SH_IR;
        `JTDR_TAP_EX1_IR: tap_next = m ? `JTDR_TAP_UP_IR : `JTDR_TAP_PA_IR;
        `JTDR_TAP_PA_IR: tap_next = m ? `JTDR_TAP_EX2_IR : `JTDR_TAP_PA_IR;
        `JTDR_TAP_EX2_IR: tap_next = m ? `JTDR_TAP_UP_IR : `JTDR_TAP_SH_IR;
        `JTDR_TAP_UP_IR: tap_next = m ? `JTDR_TAP_SEL_DR : `JTDR_TAP_IDLE;
        default: tap_next = `JTDR_TAP_RESET;
      endcase
    end
  endfunction

  reg [3:0] tap_r;
  reg [`JTDR_IR_W-1:0] ir_shift_r;
  reg [`JTDR_IR_W-1:0] ir_r;
  reg skip_r;
  reg [`JTDR_SIG_W-1:0] sig_r;
  // test reset: the synchronised pin only; the reset state just reloads IDCODE
  wire test_rst = ~trst_b_s;
  wire in_reset = (tap_r == `JTDR_TAP_RESET);
  wire st_cap_dr = (tap_r == `JTDR_TAP_CAP_DR);
  wire st_sh_dr = (tap_r == `JTDR_TAP_SH_DR);
  wire st_up_dr = (tap_r == `JTDR_TAP_UP_DR);
  wire st_cap_ir = (tap_r == `JTDR_TAP_CAP_IR);
  wire st_sh_ir = (tap_r == `JTDR_TAP_SH_IR);
  wire st_up_ir = (tap_r == `JTDR_TAP_UP_IR);

  // instruction decode, private codes fall back to the skip register
  wire op_extest = (ir_r == `JTDR_OP_EXTEST);
  wire op_sample = (ir_r == `JTDR_OP_SAMPLE);
  wire op_clamp = (ir_r == `JTDR_OP_CLAMP);
  wire op_highz = (ir_r == `JTDR_OP_HIGHZ);
  wire op_idcode = (ir_r == `JTDR_OP_IDCODE);
  wire sel_chain = op_extest | op_sample;
  wire sel_sig = op_idcode;
  wire [`JTDR_SIG_W-1:0] sig_word = {SIG_VERSION, SIG_FIXED};

  // everything moves only on a test clock edge, so a stopped clock holds state
  always @(posedge clk) begin
    if (!rst_b || test_rst) begin
      tap_r <= `JTDR_TAP_RESET;
      ir_shift_r <= `JTDR_IR_CAPTURE;
      ir_r <= `JTDR_OP_IDCODE;
      skip_r <= `JTDR_BYP_CAPTURE;
      sig_r <= {`JTDR_SIG_W{1'b0}};
    end else if (tck_rise) begin
      tap_r <= tap_next(tap_r, tms_s);
      if (st_cap_ir) begin
        ir_shift_r <= `JTDR_IR_CAPTURE;
      end else if (st_sh_ir) begin
        ir_shift_r <= {tdi_s, ir_shift_r[`JTDR_IR_W-1:1]};
      end
      if (in_reset) begin
        ir_r <= `JTDR_OP_IDCODE;
      end else if (st_up_ir) begin
        ir_r <= ir_shift_r;
      end
      if (st_cap_dr) begin
        skip_r <= `JTDR_BYP_CAPTURE;
        sig_r <= sig_word;
      end else if (st_sh_dr) begin
        skip_r <= tdi_s;
        sig_r <= {tdi_s, sig_r[`JTDR_SIG_W-1:1]};
      end
    end
  end

  // chain capture vector: inputs from pads, outputs as driven to pads
  wire [N-1:0] chain_upd;
  wire [N_IN-1:0] upd_in = chain_upd[N_IN-1:0];
  wire [N_OUT-1:0] upd_out = chain_upd[N_IN+N_OUT-1:N_IN];
  wire upd_dbe = chain_upd[N_IN+N_OUT];
  wire [N_DBUS-1:0] upd_din = chain_upd[N_IN+N_OUT+N_DBUS:N_IN+N_OUT+1];
  wire [N_DBUS-1:0] upd_dout = chain_upd[N-1:N_IN+N_OUT+N_DBUS+1];
  wire chain_out;
  wire [N-1:0] chain_cap = {pad_dbus_out, pad_dbus_in, pad_dbus_oe, pad_out, pad_in};

  jtdr_cell_chain #(
    .N(N)
  ) u_chain (
    .clk(clk),
    .rst_b(rst_b),
    .capture_en(tck_rise & st_cap_dr & sel_chain),
    .shift_en(tck_rise & st_sh_dr & sel_chain),
    .update_en(tck_rise & st_up_dr & sel_chain),
    .clr(test_rst),
    .serial_in(tdi_s),
    .capture_vals(chain_cap),
    .serial_out(chain_out),
    .update_vals(chain_upd)
  );

  // extest drives pads and core inputs from latches, clamp only the pads; other modes are straight through
  wire test_mode = op_extest | op_clamp;
  assign pad_out = test_mode ? upd_out : core_out;
  assign core_in = op_extest ? upd_in : pad_in;
  assign pad_dbus_out = test_mode ? upd_dout : core_dbus_out;
  assign pad_dbus_oe = test_mode ? upd_dbe : core_dbus_oe;
  assign core_dbus_in = op_extest ? upd_din : pad_dbus_in;
  assign pads_highz = op_highz;
  assign active_instr = ir_r;

  // output mux: skip register feeds only this path, never a pin or core signal
  reg tdo_nxt;
  always @* begin
    if (st_sh_ir) begin
      tdo_nxt = ir_shift_r[0];
    end else if (sel_chain) begin
      tdo_nxt = chain_out;
    end else if (sel_sig) begin
      tdo_nxt = sig_r[0];
    end else begin
      tdo_nxt = skip_r;
    end
  end

  // output is retimed on the falling test clock edge
  always @(posedge clk) begin
    if (!rst_b || test_rst) begin
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (tck_fall) begin
      tdo <= tdo_nxt;
      tdo_oe <= st_sh_dr | st_sh_ir;
    end
  end
endmodule
`default_nettype wire

/* test/jtdr_props.sv */
// port assertions for the test data register block
`timescale 1ns/1ns
`default_nettype none
`include "jtdr_map.vh"
module jtdr_props #(
  parameter N_IN = 4,
  parameter N_OUT = 4
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic tck,
  input wire logic tdo,
  input wire logic tdo_oe,
  input wire logic [N_IN-1:0] pad_in,
  input wire logic [N_IN-1:0] core_in,
  input wire logic [N_OUT-1:0] core_out,
  input wire logic [N_OUT-1:0] pad_out,
  input wire logic core_dbus_oe,
  input wire logic pad_dbus_oe,
  input wire logic pads_highz,
  input wire logic [4:0] active_instr
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire logic sys_mode = active_instr == `JTDR_OP_SAMPLE || active_instr == `JTDR_OP_IDCODE
    || active_instr == `JTDR_OP_BYPASS;
  sequence s_clamp_held;
    (active_instr == `JTDR_OP_CLAMP) [*2];
  endsequence
  property p_tdo_on_low; $changed(tdo) |-> !tck; endproperty
  a_tdo_on_low: assert property (p_tdo_on_low) else $error("tdo moved while tck high");
  property p_oe_on_low; $changed(tdo_oe) |-> !tck; endproperty
  a_oe_on_low: assert property (p_oe_on_low) else $error("tdo enable moved while tck high");
  property p_highz_flag; pads_highz == (active_instr == `JTDR_OP_HIGHZ); endproperty
  a_highz_flag: assert property (p_highz_flag) else $error("highz flag wrong");
  property p_sys_pass; sys_mode |-> pad_out == core_out && core_in == pad_in && pad_dbus_oe == core_dbus_oe; endproperty
  a_sys_pass: assert property (p_sys_pass) else $error("system mode not straight through");
  property p_clamp_hold; s_clamp_held |-> $stable(pad_out) && $stable(pad_dbus_oe); endproperty
  a_clamp_hold: assert property (p_clamp_hold) else $error("clamp values moved");
  property p_extest_core;
    active_instr == `JTDR_OP_EXTEST && $stable(active_instr) && $changed(core_out) |-> $stable(pad_out);
  endproperty
  a_extest_core: assert property (p_extest_core) else $error("extest pads follow core");
  property p_instr_in_shift; tdo_oe |-> $stable(active_instr); endproperty
  a_instr_in_shift: assert property (p_instr_in_shift) else $error("instruction moved in shift");
  property p_reset_idcode; $rose(rst_b) |-> active_instr == `JTDR_OP_IDCODE && !tdo_oe; endproperty
  a_reset_idcode: assert property (p_reset_idcode) else $error("reset state wrong");
endmodule
`default_nettype wire

/* test/jtdr_tester.sv */
// boundary-scan tester model driving the test port pins
`timescale 1ns/1ns
`default_nettype none
module jtdr_tester (
  input wire logic clk,
  input wire logic tdo,
  input wire logic tdo_oe,
  output logic tck,
  output logic tms,
  output logic tdi,
  output logic trst_b
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
    trst_b = 1'b0;
  end
  // one test clock of 9 clk; tck stands low between calls
  task automatic step(input logic m, input logic b, output logic q, output logic o);
    @(negedge clk);
    // a released line shows no stale value
    q = tdo_oe ? tdo : ~tdo;
    o = tdo_oe;
    @(posedge clk);
    tms <= m;
    tdi <= b;
    @(posedge clk);
    tck <= 1'b1;
    repeat (3) @(posedge clk);
    tck <= 1'b0;
    // tdo follows the fall four clk later, through the synchroniser
    repeat (4) @(posedge clk);
  endtask
  task automatic reset_tap;
    logic q, o;
    @(posedge clk);
    trst_b <= 1'b0;
    tms <= 1'b1;
    repeat (6) @(posedge clk);
    trst_b <= 1'b1;
    repeat (6) @(posedge clk);
    step(1'b0, 1'b1, q, o);
  endtask
  // from idle through capture and shift, lsb first, back to idle
  task automatic shift(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout,
                       output logic oe);
    logic q, o;
    step(1'b1, 1'b1, q, o);
    if (ir) step(1'b1, 1'b1, q, o);
    step(1'b0, 1'b1, q, o);
    step(1'b0, 1'b1, q, o);
    dout = '0;
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q, o);
      dout[i] = q;
    end
    oe = o;
    step(1'b1, 1'b1, q, o);
    step(1'b0, 1'b1, q, o);
  endtask
endmodule
`default_nettype wire

/* test/tb.sv */
// self-checking bench for the test data register block
`timescale 1ns/1ns
`default_nettype none
`include "jtdr_map.vh"
module tb;
  localparam logic [3:0] VER = 4'h3;
  // arbitrary neutral code
  localparam logic [27:0] FIX = 28'h00000A5;
  localparam logic [16:0] PAT = {4'h9, 4'h6, 1'b0, 4'hE, 4'h7};
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic tck, tms, tdi, trst_b, tdo, tdo_oe, pads_highz, pad_dbus_oe, oe;
  logic core_dbus_oe = 1'b0;
  logic [3:0] pad_in = 4'h0, core_out = 4'h0, core_dbus_out = 4'h0, pad_dbus_in = 4'h0;
  logic [3:0] core_in, pad_out, core_dbus_in, pad_dbus_out;
  logic [4:0] active_instr;
  logic [31:0] d;
  int errors = 0;
  int cmp_count = 0;
  always #20 clk = ~clk;
  jtdr_top #(.SIG_VERSION(VER), .SIG_FIXED(FIX)) DUT (.clk(clk), .rst_b(rst_b), .tck(tck), .tms(tms),
    .tdi(tdi), .trst_b(trst_b), .tdo(tdo), .tdo_oe(tdo_oe), .pad_in(pad_in), .core_in(core_in),
    .core_out(core_out), .pad_out(pad_out), .core_dbus_out(core_dbus_out), .core_dbus_oe(core_dbus_oe),
    .pad_dbus_in(pad_dbus_in), .core_dbus_in(core_dbus_in), .pad_dbus_out(pad_dbus_out),
    .pad_dbus_oe(pad_dbus_oe), .pads_highz(pads_highz), .active_instr(active_instr));
  jtdr_tester u_tst (.clk(clk), .tdo(tdo), .tdo_oe(tdo_oe), .tck(tck), .tms(tms), .tdi(tdi), .trst_b(trst_b));
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // the chain shifts out its last cell first, so serial images are reversed
  function automatic logic [16:0] rev17(input logic [16:0] v);
    for (int i = 0; i < 17; i++) rev17[i] = v[16 - i];
  endfunction
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic t_idcode;
    u_tst.shift(1'b0, 32, 32'hFFFFFFFF, d, oe);
    chk("signature", d, {VER, FIX});
    chk("oe in shift", oe, 1);
    chk("oe idle", tdo_oe, 0);
    $display("test idcode done");
  endtask
  task automatic t_chain;
    @(posedge clk);
    pad_in <= 4'hA;
    core_out <= 4'h5;
    core_dbus_oe <= 1'b1;
    core_dbus_out <= 4'h3;
    pad_dbus_in <= 4'hC;
    u_tst.shift(1'b1, 5, `JTDR_OP_SAMPLE, d, oe);
    // guard pattern loaded before extest, nothing trusted from reset
    u_tst.shift(1'b0, 17, rev17(PAT), d, oe);
    chk("chain capture", d[16:0], rev17({4'h3, 4'hC, 1'b1, 4'h5, 4'hA}));
    chk("sample pads", pad_out, 4'h5);
    u_tst.shift(1'b1, 5, `JTDR_OP_EXTEST, d, oe);
    chk("extest pads", pad_out, PAT[7:4]);
    chk("dbus enable", pad_dbus_oe, PAT[8]);
    chk("dbus out", pad_dbus_out, PAT[16:13]);
    chk("extest core in", core_in, PAT[3:0]);
    chk("extest dbus in", core_dbus_in, PAT[12:9]);
    core_out <= 4'hF;
    repeat (4) @(posedge clk);
    chk("extest hold", pad_out, PAT[7:4]);
    $display("test chain done");
  endtask
  task automatic t_codes;
    logic [4:0] ops [7] = '{`JTDR_OP_CLAMP, `JTDR_OP_HIGHZ, `JTDR_OP_BYPASS, 5'h02,
                            `JTDR_OP_SAMPLE, `JTDR_OP_EXTEST, `JTDR_OP_IDCODE};
    foreach (ops[i]) begin
      u_tst.shift(1'b1, 5, ops[i], d, oe);
      chk("ir capture", d[4:0], `JTDR_IR_CAPTURE);
      if (ops[i] != 5'h02) chk("instr", active_instr, ops[i]);
      chk("highz flag", pads_highz, ops[i] == `JTDR_OP_HIGHZ);
      if (ops[i] == `JTDR_OP_IDCODE) t_idcode;
      else if (ops[i] != `JTDR_OP_SAMPLE && ops[i] != `JTDR_OP_EXTEST) begin
        u_tst.shift(1'b0, 3, 32'h5, d, oe);
        chk("skip path", d[2:0], 3'b010);
        chk("pads", pad_out, ops[i] == `JTDR_OP_CLAMP ? PAT[7:4] : core_out);
      end
    end
    $display("test codes done");
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    u_tst.reset_tap;
    t_idcode;
    t_chain;
    // test clock stopped for a while; latches must hold
    repeat (40) @(posedge clk);
    t_codes;
    wrap_up;
  end
  initial begin
    repeat (100000) @(posedge clk);
    errors++;
    $display("run limit reached");
    wrap_up;
  end
endmodule
bind jtdr_top jtdr_props #(.N_IN(N_IN), .N_OUT(N_OUT)) u_props (.clk(clk), .rst_b(rst_b), .tck(tck),
  .tdo(tdo), .tdo_oe(tdo_oe), .pad_in(pad_in), .core_in(core_in), .core_out(core_out), .pad_out(pad_out),
  .core_dbus_oe(core_dbus_oe), .pad_dbus_oe(pad_dbus_oe), .pads_highz(pads_highz), .active_instr(active_instr));
`default_nettype wire
